// File: rtl/lfa_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lfa_consts.svh"
module lfa_top (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  // link byte stream in
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  // link byte stream out
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  // option byte one shadow and controller state
  input  wire logic        protect_level_one_option_i,
  input  wire logic        readwrite_protect_option_i,
  input  wire logic        fc_unlocked_i,
  input  wire logic        fc_busy_i,
  input  wire logic        fc_erase_start_i,
  input  wire logic [7:0]  fc_rdata_i,
  // flash controller register port
  output logic             fc_wr_o,
  output logic             fc_rd_o,
  output logic [7:0]       fc_addr_o,
  output logic [7:0]       fc_wdata_o,
  // flash array port
  output logic             fl_prog_o,
  output logic             fl_rd_o,
  output logic [15:0]      fl_addr_o,
  output logic [7:0]       fl_wdata_o,
  input  wire logic [7:0]  fl_rdata_i,
  // link-owner qualifiers for the controller
  output logic             sector_protect_bypass_o,
  output logic             mass_erase_allow_o
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // command state
  // ****************************************
  lfa_pkg::lfa_state_t state;
  logic [7:0]  cmd;
  logic [31:0] args;
  logic [2:0]  arg_cnt;
  logic [1:0]  rd_cnt;
  logic        flash_access_mode_bit;
  logic        operation_pending;
  logic        seq_load;
  logic        seq_step;
  logic        seq_last;
  logic [15:0] seq_addr;
  logic [15:0] next_addr;
  logic [16:0] next_count;
  logic [2:0]  need_args;
  logic        wr_take;
  logic        prog_ok;
  logic        mem_protected;
  logic [7:0]  status;
  logic        seq_last_q;
  logic [31:0] arg_word;
  logic [15:0] prog_addr;

  // status bits 6 and 5 read 0 when the protection is enabled
  assign status = {flash_access_mode_bit,
                   protect_level_one_option_i,
                   readwrite_protect_option_i,
                   1'b0, operation_pending, 3'b000};
  assign mem_protected = !readwrite_protect_option_i;
  assign need_args = (cmd == `LFA_CMD_WR_FCR || cmd == `LFA_CMD_RD_FCR) ?
                     `LFA_FCR_ARGS : `LFA_MEM_ARGS;
  // no buffering: a byte is only taken once the last one is done
  assign rx_ready_o = (state == lfa_pkg::LFA_S_CMD) ||
                      (state == lfa_pkg::LFA_S_ARG) ||
                      (state == lfa_pkg::LFA_S_WDAT);
  assign wr_take = (state == lfa_pkg::LFA_S_WDAT) && rx_valid_i;
  // sector protect plays no part here, only mode, unlock and option protection
  assign prog_ok = flash_access_mode_bit && fc_unlocked_i &&
                   !mem_protected;
  assign sector_protect_bypass_o = flash_access_mode_bit;
  assign mass_erase_allow_o = flash_access_mode_bit;
  assign fl_rd_o = (state == lfa_pkg::LFA_S_RD) && (rd_cnt == 2'h0) &&
                   (cmd == `LFA_CMD_RD_MEM);
  assign fc_rd_o = (state == lfa_pkg::LFA_S_RD) && (rd_cnt == 2'h0) &&
                   (cmd == `LFA_CMD_RD_FCR) && flash_access_mode_bit;
  // the sequencer has already stepped when a write pulse goes out
  assign fl_addr_o = fl_prog_o ? prog_addr : seq_addr;
  assign fc_addr_o = fc_wr_o ? prog_addr[7:0] : seq_addr[7:0];

  // arguments: 3 bytes for controller registers, 4 for memory
  // the last argument byte is loaded straight from the link, not from args
  assign arg_word = {args[23:0], rx_data_i};
  always_comb begin
    if (need_args == `LFA_FCR_ARGS) begin
      next_addr  = {8'h00, arg_word[15:8]};
      next_count = (arg_word[7:0] == 8'h00) ? `LFA_FCR_MAX : {9'h000, arg_word[7:0]};
    end else begin
      next_addr  = arg_word[31:16];
      next_count = (arg_word[15:0] == 16'h0000) ? `LFA_MEM_MAX : {1'b0, arg_word[15:0]};
    end
  end

  assign seq_load = (state == lfa_pkg::LFA_S_ARG) && rx_valid_i &&
                    (arg_cnt == need_args - 3'h1);
  assign seq_step = wr_take ||
                    ((state == lfa_pkg::LFA_S_TX) && tx_ready_i);

  lfa_seq u_seq (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .load_i  (seq_load),
    .step_i  (seq_step),
    .addr_i  ({next_addr[15:8], next_addr[7:0] ^ 8'h00}),
    .count_i (next_count),
    .addr_o  (seq_addr),
    .last_o  (seq_last)
  );

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state   <= lfa_pkg::LFA_S_CMD;
      cmd     <= 8'h00;
      args    <= 32'h0000_0000;
      arg_cnt <= 3'h0;
      rd_cnt  <= 2'h0;
    end else begin
      unique case (state)
        lfa_pkg::LFA_S_CMD: begin
          arg_cnt <= 3'h0;
          if (rx_valid_i) begin
            cmd <= rx_data_i;
            unique case (rx_data_i)
              `LFA_CMD_RD_STAT, `LFA_CMD_RD_CTL: state <= lfa_pkg::LFA_S_TX;
              `LFA_CMD_WR_CTL:                   state <= lfa_pkg::LFA_S_WDAT;
              `LFA_CMD_WR_FCR, `LFA_CMD_RD_FCR,
              `LFA_CMD_WR_MEM, `LFA_CMD_RD_MEM:  state <= lfa_pkg::LFA_S_ARG;
              default:                           state <= lfa_pkg::LFA_S_CMD;
            endcase
          end
        end
        lfa_pkg::LFA_S_ARG: begin
          if (rx_valid_i) begin
            args    <= {args[23:0], rx_data_i};
            arg_cnt <= arg_cnt + 3'h1;
            if (arg_cnt == need_args - 3'h1) begin
              state <= (cmd == `LFA_CMD_WR_FCR || cmd == `LFA_CMD_WR_MEM) ?
                       lfa_pkg::LFA_S_WDAT : lfa_pkg::LFA_S_RD;
            end
          end
        end
        lfa_pkg::LFA_S_WDAT: begin
          if (rx_valid_i) begin
            if (cmd == `LFA_CMD_WR_MEM && prog_ok) begin
              state <= lfa_pkg::LFA_S_PROG;
            end else if (cmd == `LFA_CMD_WR_CTL || seq_last) begin
              state <= lfa_pkg::LFA_S_CMD;
            end
          end
        end
        lfa_pkg::LFA_S_PROG: begin
          if (!operation_pending && !fl_prog_o) begin
            state <= seq_last_q ? lfa_pkg::LFA_S_CMD : lfa_pkg::LFA_S_WDAT;
          end
        end
        lfa_pkg::LFA_S_RD: begin
          rd_cnt <= rd_cnt + 2'h1;
          if (rd_cnt == `LFA_RD_CYCLES) begin
            rd_cnt <= 2'h0;
            state  <= lfa_pkg::LFA_S_TX;
          end
        end
        lfa_pkg::LFA_S_TX: begin
          if (tx_ready_i) begin
            state <= (cmd == `LFA_CMD_RD_STAT || cmd == `LFA_CMD_RD_CTL ||
                      seq_last) ? lfa_pkg::LFA_S_CMD : lfa_pkg::LFA_S_RD;
          end
        end
      endcase
    end
  end

  // last-byte flag held across the program wait
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_last_q <= 1'b0;
    end else if (wr_take) begin
      seq_last_q <= seq_last;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flash_access_mode_bit <= 1'(`LFA_CTL_RESET >> `LFA_MODE_BIT);
    end else if (wr_take && cmd == `LFA_CMD_WR_CTL) begin
      flash_access_mode_bit <= rx_data_i[`LFA_MODE_BIT];
    end
  end

  // ****************************************
  // launches and pending status
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fl_prog_o  <= 1'b0;
      fl_wdata_o <= 8'h00;
      fc_wr_o    <= 1'b0;
      fc_wdata_o <= 8'h00;
      prog_addr  <= 16'h0000;
    end else begin
      fl_prog_o <= wr_take && cmd == `LFA_CMD_WR_MEM && prog_ok;
      fc_wr_o   <= wr_take && cmd == `LFA_CMD_WR_FCR &&
                   flash_access_mode_bit;
      if (wr_take) begin
        prog_addr  <= seq_addr;
        fl_wdata_o <= rx_data_i;
        fc_wdata_o <= rx_data_i;
      end
    end
  end

  // set wins over clear; busy is expected from the cycle after a launch
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      operation_pending <= 1'(`LFA_STAT_RESET >> `LFA_ST_PEND);
    end else if ((wr_take && cmd == `LFA_CMD_WR_MEM && prog_ok) ||
                 fc_erase_start_i) begin
      operation_pending <= 1'b1;
    end else if (!fc_busy_i && !fl_prog_o) begin
      operation_pending <= 1'b0;
    end
  end

  // ****************************************
  // answer byte
  // ****************************************
  assign tx_valid_o = (state == lfa_pkg::LFA_S_TX);
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_o <= 8'h00;
    end else if (state == lfa_pkg::LFA_S_CMD && rx_valid_i) begin
      tx_data_o <= (rx_data_i == `LFA_CMD_RD_STAT) ? status :
                   {flash_access_mode_bit, 7'h00};
    end else if (state == lfa_pkg::LFA_S_RD && rd_cnt == `LFA_RD_CYCLES) begin
      if (cmd == `LFA_CMD_RD_FCR) begin
        tx_data_o <= flash_access_mode_bit ? fc_rdata_i : `LFA_BLANK;
      end else begin
        tx_data_o <= mem_protected ? `LFA_BLANK : fl_rdata_i;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_pend_on_launch: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    fl_prog_o |-> operation_pending)
    else $error("pending not set with program launch");
  a_status_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    status[`LFA_MODE_BIT] == flash_access_mode_bit)
    else $error("status bit 7 disagrees with mode");
  a_ctl_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (wr_take && cmd == `LFA_CMD_WR_CTL) |=> flash_access_mode_bit == $past(rx_data_i[7]))
    else $error("control write not applied");
  a_fcr_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    fc_wr_o |-> $past(flash_access_mode_bit))
    else $error("controller write outside flash mode");
  a_prog_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    fl_prog_o |-> $past(fc_unlocked_i && readwrite_protect_option_i))
    else $error("program launched while locked or protected");
  a_read_blank: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (fl_rd_o && mem_protected) |-> ##3 (tx_valid_o && tx_data_o == `LFA_BLANK))
    else $error("protected read not blanked");
  a_read_time: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    fl_rd_o |-> !tx_valid_o ##1 !tx_valid_o ##1 !tx_valid_o ##1 tx_valid_o)
    else $error("read answer timing wrong");
  a_addr_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (seq_step && !seq_load) |=> seq_addr == $past(seq_addr) + 16'h0001)
    else $error("address did not advance");
  a_no_buffer: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == lfa_pkg::LFA_S_PROG) |-> !rx_ready_o)
    else $error("byte taken during programming");
  a_pend_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (operation_pending && !fc_busy_i && !fl_prog_o && !fc_erase_start_i)
      |=> !operation_pending)
    else $error("pending did not clear");
endmodule
`default_nettype wire

// File: rtl/lfa_consts.svh
//
// Contract
// - link program and page erase ignore the sector protect settings
// - mass erase requested over the link is accepted and executed
// - other sizes give sequential programming, one data byte per location
// - no data buffering; host paces bytes to the 65 us program time
// - reads work alike; each flash read takes three clocks, unbuffered
// - control bit 7 resets to 0; 1 enters flash-control mode, 0 leaves
// - status bit 7 shows flash-control mode; status resets to zero except the option bits 6 and 5
// - status bit 6 mirrors the level-one protect option, 0 when enabled
// - status bit 5 mirrors the read/write protect option, 0 when enabled
// - status bit 3 is 1 while a link program or erase runs
// - 04H writes control, 05H reads control, 02H reads status
// - outside flash-control mode controller writes drop, reads give FFH
// - flash writes drop when locked or into read/write protected areas
// - protected main memory reads return FFH per byte
`ifndef LFA_CONSTS_SVH
`define LFA_CONSTS_SVH
// ****************************************
// command codes
// ****************************************
`define LFA_CMD_RD_STAT 8'h02
`define LFA_CMD_WR_CTL  8'h04
`define LFA_CMD_RD_CTL  8'h05
`define LFA_CMD_WR_FCR  8'h08
`define LFA_CMD_RD_FCR  8'h09
`define LFA_CMD_WR_MEM  8'h0A
`define LFA_CMD_RD_MEM  8'h0B
// ****************************************
// fields and values
// ****************************************
`define LFA_MODE_BIT    7
`define LFA_ST_PROT1    6
`define LFA_ST_RWP      5
`define LFA_ST_PEND     3
`define LFA_CTL_RESET   8'h00
`define LFA_STAT_RESET  8'h00
`define LFA_BLANK       8'hFF
`define LFA_FCR_ARGS    3'h3
`define LFA_MEM_ARGS    3'h4
`define LFA_FCR_MAX     17'h0_0100
`define LFA_MEM_MAX     17'h1_0000
// ****************************************
// timing
// ****************************************
`define LFA_RD_CYCLES   2'h2
`define LFA_PROG_TIME_NS 65000
`define LFA_CLK_NS       50
`endif

// File: rtl/lfa_pkg.sv
package lfa_pkg;
  typedef enum logic [5:0] {
    LFA_S_CMD  = 6'h01,
    LFA_S_ARG  = 6'h02,
    LFA_S_WDAT = 6'h04,
    LFA_S_PROG = 6'h08,
    LFA_S_RD   = 6'h10,
    LFA_S_TX   = 6'h20
  } lfa_state_t;
endpackage

// File: rtl/lfa_seq.sv
`timescale 1ns/1ps
`default_nettype none
// address and byte-count sequencer for one command
module lfa_seq (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        load_i,
  input  wire logic        step_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [16:0] count_i,
  // state
  output logic      [15:0] addr_o,
  output logic             last_o
);
  logic [16:0] remain;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_o <= 16'h0000;
      remain <= 17'h0_0000;
    end else if (load_i) begin
      addr_o <= addr_i;
      remain <= count_i;
    end else if (step_i) begin
      addr_o <= addr_o + 16'h0001;
      remain <= remain - 17'h0_0001;
    end
  end

  assign last_o = (remain == 17'h0_0001);
endmodule
`default_nettype wire

// File: verif/lfa_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// programming host on the link byte stream
// ****************************************
module lfa_host (
  // clock
  input  wire logic       clk_i,
  // bytes towards the device
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  // bytes from the device
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  int tmo = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b0;
  end
  // ready only moves on edges, so it is read one step after the edge before
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    // one idle edge between bytes so valid is never lowered and raised at once
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b1;
    rx_data_o  = b;
    while (!rx_ready_i && n < 5000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 5000) tmo++;
    @(posedge clk_i);
    #1;
    rx_valid_o = 1'b0;
    // inverse of the last byte so a stale line never looks valid
    rx_data_o  = ~b;
  endtask
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_i);
    #1;
    tx_ready_o = 1'b1;
    while (!tx_valid_i && n < 5000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 5000) tmo++;
    b = tx_data_i;
    @(posedge clk_i);
    #1;
    tx_ready_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench for the link flash access block
// ****************************************
module testbench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  int          failures = 0;
  int          checks = 0;
  int          seed = 32'h2837;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, fc_wr, fc_rd, fl_prog, fl_rd, byp, mea;
  logic [7:0]  rx_data, tx_data, fc_addr, fc_wdata, fl_wdata, fc_rdata, fl_rdata, fc_d, b;
  logic [15:0] fl_addr, a, rd_a;
  logic [7:0]  fc_a = 8'h00;
  logic        prot1 = 1'b1, rwp = 1'b1, unl = 1'b1, erase = 1'b0;
  int          busy_cnt = 0, fc_n = 0;
  logic        fc_busy;
  logic [7:0]  fc_wa;
  logic [15:0] pa[$];
  logic [7:0]  pd[$];
  always #25 clk = ~clk;
  lfa_top u_dut (
    .ref_clk_i                  (clk),
    .resetn_i                   (rst_n),
    .rx_valid_i                 (rx_valid),
    .rx_data_i                  (rx_data),
    .rx_ready_o                 (rx_ready),
    .tx_valid_o                 (tx_valid),
    .tx_data_o                  (tx_data),
    .tx_ready_i                 (tx_ready),
    .protect_level_one_option_i (prot1),
    .readwrite_protect_option_i (rwp),
    .fc_unlocked_i              (unl),
    .fc_busy_i                  (fc_busy),
    .fc_erase_start_i           (erase),
    .fc_rdata_i                 (fc_rdata),
    .fc_wr_o                    (fc_wr),
    .fc_rd_o                    (fc_rd),
    .fc_addr_o                  (fc_addr),
    .fc_wdata_o                 (fc_wdata),
    .fl_prog_o                  (fl_prog),
    .fl_rd_o                    (fl_rd),
    .fl_addr_o                  (fl_addr),
    .fl_wdata_o                 (fl_wdata),
    .fl_rdata_i                 (fl_rdata),
    .sector_protect_bypass_o    (byp),
    .mass_erase_allow_o         (mea)
  );
  lfa_host u_host (
    .clk_i      (clk),
    .rx_valid_o (rx_valid),
    .rx_data_o  (rx_data),
    .rx_ready_i (rx_ready),
    .tx_valid_i (tx_valid),
    .tx_data_i  (tx_data),
    .tx_ready_o (tx_ready)
  );
  function automatic logic [7:0] mem_of(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] st(input logic m, input logic p);
    return {m, prot1, rwp, 1'b0, p, 3'b000};
  endfunction
  // controller and array stand-in; program time shortened to 20 clocks
  always @(posedge clk) begin
    if (fl_prog || erase) busy_cnt <= 20;
    else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    if (fl_prog) begin
      pa.push_back(fl_addr);
      pd.push_back(fl_wdata);
    end
    if (fl_rd) rd_a <= fl_addr;
    if (fc_rd) fc_a <= fc_addr;
    if (fc_wr) begin
      fc_n  <= fc_n + 1;
      fc_d  <= fc_wdata;
      fc_wa <= fc_addr;
    end
  end
  assign fl_rdata = mem_of(rd_a);
  assign fc_rdata = fc_a ^ 8'hC3;
  assign fc_busy = (busy_cnt != 0);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check8(input string w, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rx_chk(input string w, input logic [7:0] e);
    logic [7:0] g;
    u_host.get(g);
    check8(w, e, g);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] x, input logic [15:0] n);
    u_host.put(op);
    u_host.put(x[15:8]);
    u_host.put(x[7:0]);
    u_host.put(n[15:8]);
    u_host.put(n[7:0]);
  endtask
  task automatic wait_prog(input int n);
    for (int i = 0; i < 300 && pa.size() < n; i++) step(1);
    step(30);
    check8("programs", 8'(n), 8'(pa.size()));
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) if (u_host.tmo != 0) begin
    failures++;
    report_and_stop();
  end
  initial begin
    #4000000;
    failures++;
    report_and_stop();
  end
  initial begin
    step(16);
    rst_n = 1'b1;
    step(4);
    prot1 = 1'($random(seed));
    u_host.put(8'h02);
    rx_chk("status", st(1'b0, 1'b0));
    u_host.put(8'h05);
    rx_chk("control", 8'h00);
    check8("bypass", 8'h00, {7'h00, byp});
    done("reset");
    u_host.put(8'h04);
    u_host.put(8'hFF);
    u_host.put(8'h05);
    rx_chk("control", 8'h80);
    u_host.put(8'h02);
    rx_chk("status", st(1'b1, 1'b0));
    check8("bypass", 8'h03, {6'h00, byp, mea});
    b = 8'($random(seed));
    a = 16'($random(seed));
    u_host.put(8'h08);
    u_host.put(8'h0F);
    u_host.put(a[7:0]);
    u_host.put(8'h01);
    u_host.put(b);
    step(4);
    check8("fc writes", 8'h01, 8'(fc_n));
    check8("fc data", b, fc_d);
    check8("fc addr", a[7:0], fc_wa);
    u_host.put(8'h09);
    u_host.put(8'h0F);
    u_host.put(a[7:0]);
    u_host.put(8'h02);
    for (int i = 0; i < 2; i++) rx_chk("fc read", (a[7:0] + 8'(i)) ^ 8'hC3);
    done("mode");
    for (int k = 0; k < 2; k++) begin
      a = 16'($random(seed));
      b = 8'($random(seed));
      cmd(8'h0A, a, 16'h0001);
      u_host.put(b);
      wait_prog(k + 1);
      check8("prog addr", a[7:0], pa[k][7:0]);
      check8("prog data", b, pd[k]);
    end
    u_host.put(8'h02);
    rx_chk("status", st(1'b1, 1'b0));
    pa.delete();
    pd.delete();
    a = 16'hFFFE;
    cmd(8'h0A, a, 16'h0003);
    for (int i = 0; i < 3; i++) u_host.put(8'(i) ^ 8'hA5);
    wait_prog(3);
    for (int i = 0; i < 3; i++) begin
      check8("seq addr lo", a[7:0] + 8'(i), pa[i][7:0]);
      check8("seq addr hi", 8'(16'(a + 16'(i)) >> 8), pa[i][15:8]);
      check8("seq data", 8'(i) ^ 8'hA5, pd[i]);
    end
    done("write");
    for (int k = 0; k < 2; k++) begin
      a = (k == 0) ? 16'hFFFE : 16'($random(seed));
      cmd(8'h0B, a, 16'h0004);
      for (int i = 0; i < 4; i++) rx_chk("read", mem_of(a + 16'(i)));
    end
    done("read");
    rwp = 1'b0;
    cmd(8'h0B, a, 16'h0002);
    for (int i = 0; i < 2; i++) rx_chk("blank read", 8'hFF);
    pa.delete();
    cmd(8'h0A, a, 16'h0001);
    u_host.put(8'h3C);
    wait_prog(0);
    rwp = 1'b1;
    unl = 1'b0;
    cmd(8'h0A, a, 16'h0001);
    u_host.put(8'h3C);
    wait_prog(0);
    unl = 1'b1;
    done("protect");
    erase = 1'b1;
    step(1);
    erase = 1'b0;
    u_host.put(8'h02);
    rx_chk("status", st(1'b1, 1'b1));
    b = 8'hFF;
    for (int i = 0; i < 50 && b[3] !== 1'b0; i++) begin
      u_host.put(8'h02);
      u_host.get(b);
    end
    check8("status", st(1'b1, 1'b0), b);
    done("erase");
    u_host.put(8'h04);
    u_host.put(8'h7F);
    u_host.put(8'h08);
    u_host.put(8'h0F);
    u_host.put(8'h00);
    u_host.put(8'h01);
    u_host.put(8'h11);
    step(4);
    check8("fc writes", 8'h01, 8'(fc_n));
    u_host.put(8'h09);
    u_host.put(8'h0F);
    u_host.put(8'h00);
    u_host.put(8'h01);
    rx_chk("fc read", 8'hFF);
    u_host.put(8'h02);
    rx_chk("status", st(1'b0, 1'b0));
    done("normal");
    report_and_stop();
  end
endmodule
`default_nettype wire
